/* rtl/icp_alu.sv */
// eight-bit arithmetic unit
`timescale 1ns/10ps
`default_nettype none
`include "icp_map.svh"
module icp_alu (
  input wire logic [3:0] op,
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  input wire logic cin,
  output icp_pkg::icp_alu_t result
);
  import icp_pkg::*;
  logic [8:0] sum; // add with carry out
  logic [8:0] r;
  assign sum = {1'b0, acc} + {1'b0, opnd};
  // operation select
  always_comb begin
    case (op)
      `ICP_OP_ADD: r = sum; // RULE_09
      `ICP_OP_AND: r = {cin, acc & opnd};
      `ICP_OP_OR: r = {cin, acc | opnd};
      `ICP_OP_XOR: r = {cin, acc ^ opnd};
      `ICP_OP_RR: r = {acc[0], acc[0], acc[7:1]}; // plain rotate, bit 0 wraps
      `ICP_OP_RL: r = {acc[7], acc[6:0], acc[7]}; // plain rotate, bit 7 wraps
      `ICP_OP_INC: r = {cin, acc + 8'h01};
      `ICP_OP_DEC: r = {cin, acc - 8'h01};
      `ICP_OP_SKZ: r = {cin, acc}; // branch decision on zero
      `ICP_OP_MOVI: r = {cin, opnd};
      default: r = {cin, acc};
    endcase
  end
  assign result.res = r[7:0];
  assign result.carry = r[8];
  assign result.zero = (r[7:0] == 8'h00);
endmodule : icp_alu
`default_nettype wire

/* rtl/icp_core.sv */
// instruction cycle sequencer with two-stage fetch/execute pipeline
`timescale 1ns/10ps
`default_nettype none
`include "icp_map.svh"
module icp_core #(
  parameter int PC_W = 15
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire icp_pkg::icp_osc_t osc_sel,
  input wire logic [3:0] osc_tick,
  input wire logic [15:0] imem_data,
  output logic [PC_W-1:0] imem_addr,
  output logic imem_rd,
  output logic [7:0] acc_out,
  output logic [PC_W-1:0] pc_out,
  output logic exec_valid,
  output logic dummy_cycle,
  output icp_pkg::icp_phase_t phase_out
);
  import icp_pkg::*;
  // ************************
  // system clock selection
  // ************************
  logic sys_en; // one enable per system clock period
  assign sys_en = osc_tick[osc_sel]; // RULE_01
  icp_phase_t ph; // phase strobes
  icp_phase_gen u_phase (
    .clk(clk),
    .sys_rst(sys_rst),
    .sys_en(sys_en),
    .cycle_phase_clocks(ph)
  );
  assign phase_out = ph;
  // ************************
  // pipeline state
  // ************************
  logic [PC_W-1:0] pc_q; // next fetch address
  logic [15:0] fb_q; // word fetched this cycle, runs next cycle
  logic fb_valid_q; // fetched word still wanted
  logic is_ext_pend_q; // word now in the fetch buffer is an operand
  logic [15:0] ir_q; // prefetched word for execution
  logic ir_valid_q; // prefetched word is usable
  logic ext_q; // second word of extended op pending
  logic [7:0] ext_op_q; // operand from the second word low byte
  logic [3:0] ext_code_q;
  logic [7:0] acc_q; // accumulator
  logic c_q; // carry
  logic exec_q; // instruction retired
  logic dummy_q; // dummy cycle marker
  // ************************
  // decode of the word under execution
  // ************************
  wire [3:0] opc = ir_q[15:12];
  wire [7:0] imm = ir_q[7:0];
  wire do_exec = ph.t4 && ir_valid_q && !ext_q; // RULE_04
  wire is_jump = (opc == `ICP_OP_JMP) || (opc == `ICP_OP_CALL);
  wire is_pcl = (opc == `ICP_OP_MOVPCL);
  wire is_ext = (opc == `ICP_OP_EXT);
  icp_alu_t alu_r;
  wire [3:0] alu_op = ext_q ? ext_code_q : opc;
  wire [7:0] alu_b = ext_q ? ext_op_q : imm;
  icp_alu u_alu (
    .op(alu_op),
    .acc(acc_q),
    .opnd(alu_b),
    .cin(c_q),
    .result(alu_r)
  );
  wire skip_taken = (opc == `ICP_OP_SKZ) && alu_r.zero; // RULE_12
  wire take_jump = do_exec && is_jump; // RULE_08
  wire take_pcl = do_exec && is_pcl; // RULE_13
  wire take_skip = do_exec && skip_taken;
  wire flush = take_jump || take_pcl || take_skip; // RULE_15
  wire ext_done = ph.t4 && ext_q; // RULE_06
  wire alu_wr = (do_exec && !is_jump && !is_pcl && !is_ext && (opc != `ICP_OP_SKZ)
                 && (opc != `ICP_OP_NOP)) || ext_done;
  // ************************
  // next program counter
  // ************************
  logic [PC_W-1:0] pc_d;
  wire [PC_W-1:0] jmp_tgt = PC_W'(ir_q[11:0]);
  wire [PC_W-1:0] pcl_tgt = {pc_q[PC_W-1:`ICP_PAGE_BITS], acc_q};
  always_comb begin
    if (take_jump) begin
      pc_d = jmp_tgt; // RULE_07
    end else if (take_pcl) begin
      pc_d = pcl_tgt; // page jump, refetch RULE_13
    end else if (ph.t1) begin
      pc_d = pc_q + PC_W'(1); // RULE_03 RULE_11
    end else begin
      pc_d = pc_q;
    end
  end
  // fetch address: pc before increment in phase one
  assign imem_addr = pc_q;
  assign imem_rd = ph.t1; // RULE_03
  // ************************
  // pc and instruction register
  // ************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= `ICP_PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end
  // fetch buffer: word taken in phase one, dropped on a flush
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fb_q <= 16'h0000;
      fb_valid_q <= 1'b0; // RULE_14
    end else if (ph.t1) begin
      fb_q <= imem_data; // RULE_05
      fb_valid_q <= 1'b1;
    end else if (flush) begin
      fb_valid_q <= 1'b0; // RULE_15
    end
  end
  // execute stage takes the word fetched one cycle earlier
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_q <= 16'h0000;
      ir_valid_q <= 1'b0; // RULE_14
    end else if (ph.t1) begin
      ir_q <= fb_q; // RULE_04
      ir_valid_q <= fb_valid_q && !is_ext_pend_q;
    end
  end
  // extended word: second word is operand
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      is_ext_pend_q <= 1'b0;
    end else if (do_exec && is_ext) begin
      is_ext_pend_q <= 1'b1;
    end else if (ph.t1) begin
      is_ext_pend_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_q <= 1'b0;
      ext_code_q <= 4'h0;
      ext_op_q <= 8'h00;
    end else if (ph.t1 && is_ext_pend_q) begin
      ext_q <= 1'b1; // RULE_06
      ext_code_q <= ir_q[11:8];
      ext_op_q <= fb_q[7:0];
    end else if (ext_done) begin
      ext_q <= 1'b0;
    end
  end
  // ************************
  // accumulator datapath
  // ************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= 8'h00;
      c_q <= 1'b0;
    end else if (alu_wr) begin
      acc_q <= alu_r.res; // RULE_10
      c_q <= alu_r.carry;
    end
  end
  // ************************
  // status markers
  // ************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      exec_q <= 1'b0;
      dummy_q <= 1'b0;
    end else begin
      exec_q <= do_exec || ext_done;
      dummy_q <= ph.t4 && !ir_valid_q && !ext_q; // RULE_12
    end
  end
  assign acc_out = acc_q;
  assign pc_out = pc_q;
  assign exec_valid = exec_q;
  assign dummy_cycle = dummy_q;
endmodule : icp_core
`default_nettype wire

/* rtl/icp_map.svh */
// constants for the instruction cycle pipeline
// Functional notes
// RULE_01 - clock from one of four oscillators
// RULE_02 - four non-overlapping phases form one cycle
// RULE_03 - pc advances, fetch starts in phase one
// RULE_04 - phases two to four decode and execute
// RULE_05 - fetch overlaps execute, one cycle each
// RULE_06 - extended instructions take two cycles
// RULE_07 - pc-changing instructions cost one extra cycle
// RULE_08 - jump: get target, then transfer
// RULE_09 - eight-bit alu does all operations
// RULE_10 - data flows via accumulator and alu
// RULE_11 - pc increments unless jump loads target
// RULE_12 - taken skip replaces prefetch with dummy
// RULE_13 - pc low write jumps within page, dummy
// RULE_14 - reset restarts phase one, pipeline empty
// RULE_15 - taken branch flushes prefetched instruction
`ifndef ICP_MAP_SVH
`define ICP_MAP_SVH
`define ICP_PHASES 4
`define ICP_PC_RESET 15'h0000
`define ICP_PAGE_BITS 8
`define ICP_OP_NOP 4'h0
`define ICP_OP_JMP 4'h1
`define ICP_OP_CALL 4'h2
`define ICP_OP_SKZ 4'h3
`define ICP_OP_ADD 4'h4
`define ICP_OP_AND 4'h5
`define ICP_OP_OR 4'h6
`define ICP_OP_XOR 4'h7
`define ICP_OP_RR 4'h8
`define ICP_OP_RL 4'h9
`define ICP_OP_INC 4'ha
`define ICP_OP_DEC 4'hb
`define ICP_OP_MOVPCL 4'hc
`define ICP_OP_EXT 4'hd
`define ICP_OP_MOVI 4'he
`endif

/* rtl/icp_phase_gen.sv */
// four-phase generator for the instruction cycle
`timescale 1ns/10ps
`default_nettype none
`include "icp_map.svh"
module icp_phase_gen (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sys_en,
  output icp_pkg::icp_phase_t cycle_phase_clocks
);
  import icp_pkg::*;
  // ****************
  // phase counter
  // ****************
  logic [1:0] ph_q; // current phase
  logic [1:0] ph_d;
  assign ph_d = sys_en ? ph_q + 2'h1 : ph_q;
  // restart at the first phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q <= 2'h0; // RULE_14
    end else begin
      ph_q <= ph_d;
    end
  end
  // one strobe per phase, never two at once
  assign cycle_phase_clocks.t1 = sys_en && (ph_q == 2'h0); // RULE_02
  assign cycle_phase_clocks.t2 = sys_en && (ph_q == 2'h1);
  assign cycle_phase_clocks.t3 = sys_en && (ph_q == 2'h2);
  assign cycle_phase_clocks.t4 = sys_en && (ph_q == 2'h3);
endmodule : icp_phase_gen
`default_nettype wire

/* rtl/icp_pkg.sv */
// types for the instruction cycle pipeline
package icp_pkg;
  // oscillator selection
  typedef enum logic [1:0] {
    ext_fast_crystal_osc, ext_slow_crystal_osc, int_fast_rc_osc, int_slow_rc_osc
  } icp_osc_t;
  // one-hot phase strobes
  typedef struct packed {
    logic t4;
    logic t3;
    logic t2;
    logic t1;
  } icp_phase_t;
  // alu result
  typedef struct packed {
    logic [7:0] res;
    logic zero;
    logic carry;
  } icp_alu_t;
endpackage : icp_pkg

/* tb/icp_core_properties.sv */
// port assertions for the instruction cycle core
`timescale 1ns/10ps
`default_nettype none
module icp_chk #(parameter int PC_W = 15) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [PC_W-1:0] imem_addr,
  input wire logic imem_rd,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic exec_valid,
  input wire logic dummy_cycle,
  input wire icp_pkg::icp_phase_t phase_out
);
  import icp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic first_q; // no fetch since reset
  // cleared by the first fetch
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) first_q <= 1'h1;
    else if (imem_rd) first_q <= 1'h0;
  ph_hot_a: assert property ($onehot0(phase_out))
    else $error("phases overlap");
  ph_seq_a: assert property (phase_out.t1 |-> ##[1:8] phase_out.t2
    ##[1:8] phase_out.t3 ##[1:8] phase_out.t4) else $error("phase order");
  fetch_t1_a: assert property (imem_rd == phase_out.t1)
    else $error("fetch off phase one");
  first_addr_a: assert property (first_q && imem_rd |-> imem_addr == '0)
    else $error("first fetch not zero");
  pc_step_a: assert property (imem_rd |=> pc_out == $past(imem_addr) + 1'h1)
    else $error("pc no step");
  exec_t4_a: assert property (exec_valid |-> $past(phase_out.t4))
    else $error("retire off phase four");
  dummy_slot_a: assert property (dummy_cycle |-> $past(phase_out.t4) && !exec_valid)
    else $error("bad dummy");
  one_rate_a: assert property (exec_valid |=> !exec_valid [*3])
    else $error("retire too fast");
  cover property (exec_valid ##[1:8] dummy_cycle);
  cover property (dummy_cycle ##[1:8] exec_valid);
  cover property (imem_rd && first_q);
endmodule : icp_chk
bind icp_core icp_chk #(.PC_W(PC_W)) chk_i (.clk(clk), .sys_rst(sys_rst),
  .imem_addr(imem_addr), .imem_rd(imem_rd), .pc_out(pc_out),
  .exec_valid(exec_valid), .dummy_cycle(dummy_cycle), .phase_out(phase_out));
`default_nettype wire

/* tb/icp_mem.sv */
// program memory model feeding instruction words
`timescale 1ns/10ps
`default_nettype none
module icp_mem (
  input wire logic clk,
  input wire logic [14:0] imem_addr,
  input wire logic imem_rd,
  output logic [15:0] imem_data
);
  logic [15:0] mem [0:255]; // program image, loaded by the bench
  logic [15:0] junk_q = 16'h5a5a; // filler that moves every clock
  always @(posedge clk) junk_q <= junk_q + 16'h1357;
  // word is only valid while a fetch asks for it
  assign imem_data = imem_rd ? mem[imem_addr[7:0]] : junk_q;
endmodule : icp_mem
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the instruction cycle core
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import icp_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  icp_osc_t osc_sel = ext_fast_crystal_osc;
  logic [3:0] osc_tick = 4'h0;
  logic tgl = 1'h0;
  logic [15:0] imem_data;
  logic [14:0] imem_addr, pc_out;
  logic imem_rd, exec_valid, dummy_cycle;
  logic [7:0] acc_out;
  icp_phase_t phase_out;
  int mismatches = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  // chosen source ticks on odd clocks, the others on even ones
  always @(posedge clk) begin
    tgl <= ~tgl;
    osc_tick <= tgl ? 4'h1 << osc_sel : ~(4'h1 << osc_sel);
  end
  icp_core DUT (.clk(clk), .sys_rst(sys_rst), .osc_sel(osc_sel), .osc_tick(osc_tick),
    .imem_data(imem_data), .imem_addr(imem_addr), .imem_rd(imem_rd), .acc_out(acc_out),
    .pc_out(pc_out), .exec_valid(exec_valid), .dummy_cycle(dummy_cycle),
    .phase_out(phase_out));
  icp_mem pm (.clk(clk), .imem_addr(imem_addr), .imem_rd(imem_rd), .imem_data(imem_data));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // load program, rest nops, reset six clocks
  task automatic rst(input logic [15:0] p[6]);
    @(posedge clk);
    sys_rst <= 1'h1;
    for (int i = 0; i < 256; i++) pm.mem[i] = i < 6 ? p[i] : 16'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    #1;
    chk(pc_out, 16'h0);
    chk(acc_out, 16'h0);
  endtask : rst
  // wait for the next retire or dummy slot
  task automatic nxt(output logic d, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (exec_valid !== 1'h1 && dummy_cycle !== 1'h1 && k < 64);
    d = dummy_cycle;
  endtask : nxt
  // each source alone paces the phases
  task automatic t_osc;
    logic d;
    int k;
    for (int s = 0; s < 4; s++) begin
      osc_sel <= icp_osc_t'(s);
      rst('{6{16'h0}});
      nxt(d, k);
      nxt(d, k);
      nxt(d, k);
      chk(k, 16'h8);
      chk(d, 1'h0);
    end
  endtask : t_osc
  // jump, call, pc-low write and taken skip each leave one dummy slot
  task automatic t_flow;
    logic [15:0] pg[4][6] = '{'{16'ha000, 16'h1004, 16'ha000, 16'ha000, 16'ha000, 16'h1005},
      '{16'ha000, 16'h2004, 16'ha000, 16'ha000, 16'ha000, 16'h1005},
      '{16'ha000, 16'hc004, 16'ha000, 16'ha000, 16'ha000, 16'h1005},
      '{16'h3000, 16'ha000, 16'ha000, 16'ha000, 16'h1004, 16'h0}};
    logic [4:0] vx[4] = '{5'h12, 5'h12, 5'h12, 5'h14};
    logic [7:0] ax[4] = '{8'h2, 8'h2, 8'h1, 8'h2};
    logic [4:0] v;
    logic d;
    int k;
    for (int i = 0; i < 4; i++) begin
      rst(pg[i]);
      for (int j = 4; j >= 0; j--) begin
        nxt(d, k);
        v[j] = d;
      end
      chk(v, vx[i]);
      chk(acc_out, ax[i]);
    end
  endtask : t_flow
  // two-word ops drive add, and, or, xor, both rotates, inc and dec
  task automatic t_alu;
    logic [3:0] op[8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    logic [7:0] ex[8] = '{8'hd2, 8'h14, 8'hbe, 8'haa, 8'h4b, 8'h2d, 8'h97, 8'h95};
    for (int i = 0; i < 8; i++) begin
      rst('{16'hd400, 16'h0096, {4'hd, op[i], 8'h0}, 16'h003c, 16'h1004, 16'h0});
      repeat (100) @(posedge clk);
      chk(acc_out, ex[i]);
    end
  endtask : t_alu
  initial begin
    t_osc();
    t_flow();
    t_alu();
    complete_run();
  end
  // cut a hang short
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
